// file: spi_frame_map.svh
// constants for the spi frame port: widths, field positions, crc figures
`ifndef SPI_FRAME_MAP_SVH
`define SPI_FRAME_MAP_SVH

`define FRAME_W        32
`define FRAME_MSB      31
`define CNT_W          6
`define FRAME_BITS     6'h20
`define CNT_ZERO       6'h00
`define CNT_ONE        6'h01
`define MOSI_RW        31
`define MOSI_ADDR_HI   30
`define MOSI_ADDR_LO   23
`define MOSI_TM        22
`define MOSI_FC        21
`define MOSI_DATA_HI   20
`define MOSI_DATA_LO   5
`define CRC_HI         4
`define CRC_LO         0
`define CRC_W          5
`define CRC_SEED       5'h1f
`define CRC_POLY       5'h05
`define CRC_SKIP       21
`define RESP_RST       32'h0000_0011   // zero answer with its own crc
`define ADDR_W         8
`define DATA_W         16
`define FAULT_W        2
`define FIFO_DEPTH     8
`define FIFO_AW        3
`define CMD_W          25

`endif

// file: spi_frame_pkg.sv
// types shared by the spi frame port
package spi_frame_pkg;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_FRAME,
        ST_CHECK,
        ST_APPLY
    } frame_state_t;
endpackage

// file: cmd_fifo.sv
// small valid/ready fifo carrying accepted commands to the register side
`timescale 1ns/1ns
module cmd_fifo #(
    parameter int WIDTH = 25,
    parameter int DEPTH = 8,
    parameter int AW    = 3
) (
    input  wire logic             ref_clk,
    input  wire logic             rstn,
    input  wire logic             clk_en,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_q;
    logic [AW:0]      wr_d;
    logic [AW:0]      rd_q;
    logic [AW:0]      rd_d;
    logic [WIDTH-1:0] out_q;
    logic [WIDTH-1:0] out_d;
    logic             push;
    logic             pop;
    logic             full;
    logic             empty;

    // full when pointers differ only in the wrap bit
    assign full  = (wr_q[AW] != rd_q[AW]) &&
                   (wr_q[AW-1:0] == rd_q[AW-1:0]);
    assign empty = (wr_q == rd_q);
    assign in_ready  = ~full;
    assign out_valid = ~empty;
    assign out_data  = out_q;
    assign push = in_valid & ~full;
    assign pop  = out_ready & ~empty;

    // next pointers; read data registered from the head slot
    always_comb
    begin
        wr_d  = wr_q;
        rd_d  = rd_q;
        out_d = mem[rd_q[AW-1:0]];
        if (push)
            wr_d = wr_q + 1'b1;
        if (pop)
        begin
            rd_d  = rd_q + 1'b1;
            out_d = mem[rd_d[AW-1:0]];
        end
        if (push && (wr_q == rd_d))
            out_d = in_data;   // write into slot about to be read
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wr_q  <= '0;
            rd_q  <= '0;
            out_q <= '0;
        end
        else if (clk_en)
        begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            out_q <= out_d;
        end
    end

    // storage has no reset, only data
    always_ff @(posedge ref_clk)
    begin
        if (clk_en && push)
            mem[wr_q[AW-1:0]] <= in_data;
    end
endmodule

// file: spi_slave_frame_port.sv
// 32-bit out-of-frame spi slave with crc, frame counter and length check
`timescale 1ns/1ns
`include "spi_frame_map.svh"

// Behaviour
// - each outgoing frame answers the previous chip-select period
// - frame opens on chip select falling, closes on it rising
// - with chip select high, clock and data ignored, sdo released
// - sdo changes on sclk rise, sdi captured on sclk fall
// - both directions shift most significant bit first
// - access bit: zero reads, one writes
// - outgoing: error, chip fault, address echo, data, crc
// - serial error bit reports outcome of previous incoming frame
// - two chip fault bits sent in every outgoing frame
// - echo last valid address and that register's contents
// - valid write updates register first, then loads output buffer
// - valid read leaves register, loads output buffer with contents
// - loaded buffer shifts out from next chip select fall
// - first frame after reset carries zero flags, address, data
// - star mode only, input never forwarded to output
// - crc x^5+x^2+1, seed all ones, msb first
// - crc covers bits 31 to 5 except bit 21: the toggle bit incoming, address echo bit 0 outgoing
// - bad length, toggle or crc sets error, frame discarded
module spi_slave_frame_port
    import spi_frame_pkg::*;
(
    input  wire logic                   ref_clk,
    input  wire logic                   rstn,
    input  wire logic                   clk_en,
    input  wire logic                   chip_select_n,
    input  wire logic                   sclk,
    input  wire logic                   sdi,
    output logic                        sdo_o,
    output logic                        sdo_oe,
    input  wire logic [`FAULT_W-1:0]    chip_fault_field,
    output logic                        reg_wr_q,
    output logic      [`ADDR_W-1:0]     reg_addr_q,
    output logic      [`DATA_W-1:0]     reg_wdata_q,
    input  wire logic [`DATA_W-1:0]     reg_rdata,
    output logic                        frame_err_q,
    output logic                        test_mode_flag_q
);
    // two-flop synchronisers for the three pins
    logic [1:0] cs_sync_q;
    logic [1:0] sck_sync_q;
    logic [1:0] sdi_sync_q;
    logic       cs_prev_q;
    logic       sck_prev_q;
    logic       cs_s;
    logic       sck_s;
    logic       sck_rise;
    logic       sck_fall;
    logic       cs_fall;
    logic       cs_rise;

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cs_sync_q  <= 2'h3;
            sck_sync_q <= 2'h0;
            sdi_sync_q <= 2'h0;
            cs_prev_q  <= 1'b1;
            sck_prev_q <= 1'b0;
        end
        else if (clk_en)
        begin
            cs_sync_q  <= {cs_sync_q[0], chip_select_n};
            sck_sync_q <= {sck_sync_q[0], sclk};
            sdi_sync_q <= {sdi_sync_q[0], sdi};
            cs_prev_q  <= cs_sync_q[1];
            sck_prev_q <= sck_sync_q[1];
        end
    end

    // edges only count while selected; idle pin activity is dropped
    assign cs_s     = cs_sync_q[1];
    assign sck_s    = sck_sync_q[1];
    assign cs_fall  = cs_prev_q & ~cs_s;
    assign cs_rise  = ~cs_prev_q & cs_s;
    assign sck_rise = ~cs_s & ~sck_prev_q & sck_s;
    assign sck_fall = ~cs_s & sck_prev_q & ~sck_s;

    // crc step, msb first, used by receive and transmit paths
    function automatic logic [`CRC_W-1:0] crc_step(
        input logic [`CRC_W-1:0] crc,
        input logic              din
    );
        logic fb;
        fb = crc[`CRC_W-1] ^ din;
        crc_step = {crc[`CRC_W-2:0], 1'b0} ^ (fb ? `CRC_POLY : 5'h00);
    endfunction

    // crc over bits 31..5 except the toggle bit
    function automatic logic [`CRC_W-1:0] frame_crc(
        input logic [`FRAME_W-1:0] w
    );
        logic [`CRC_W-1:0] c;
        c = `CRC_SEED;
        for (int i = `FRAME_MSB; i >= `MOSI_DATA_LO; i--)
        begin
            if (i != `CRC_SKIP)
                c = crc_step(c, w[i]);
        end
        frame_crc = c;
    endfunction

    // frame engine state
    frame_state_t      st_q;
    frame_state_t      st_d;
    logic [`FRAME_W-1:0] rx_q;
    logic [`FRAME_W-1:0] rx_d;
    logic [`FRAME_W-1:0] tx_q;
    logic [`FRAME_W-1:0] tx_d;
    logic [`FRAME_W-1:0] obuf_q;
    logic [`FRAME_W-1:0] obuf_d;
    logic [`CNT_W-1:0]   nrise_q;
    logic [`CNT_W-1:0]   nrise_d;
    logic [`CNT_W-1:0]   nfall_q;
    logic [`CNT_W-1:0]   nfall_d;
    logic                fc_exp_q;
    logic                fc_exp_d;
    logic                err_q;
    logic                err_d;
    logic                sdo_q;
    logic                sdo_d;
    logic                oe_q;
    logic                oe_d;
    logic [`ADDR_W-1:0]  echo_q;
    logic [`ADDR_W-1:0]  echo_d;
    logic                tm_q;
    logic                tm_d;
    logic                frame_ok;
    logic                fifo_in_ready;
    logic                cmd_valid;
    logic                cmd_pop;
    logic [`CMD_W-1:0]   cmd_word;
    logic [`CMD_W-1:0]   cmd_in;
    logic [`FRAME_W-1:0] resp_word;

    // a frame is good only with 32 edges each way, right toggle, right crc
    assign frame_ok = (nrise_q == `FRAME_BITS)
                    && (nfall_q == `FRAME_BITS)
                    && (rx_q[`MOSI_FC] == fc_exp_q)
                    && (rx_q[`CRC_HI:`CRC_LO] == frame_crc(rx_q));

    // accepted command: rw, address, data
    assign cmd_in = {rx_q[`MOSI_RW], rx_q[`MOSI_ADDR_HI:`MOSI_ADDR_LO],
                     rx_q[`MOSI_DATA_HI:`MOSI_DATA_LO]};

    // response assembled from the register side, crc appended
    always_comb
    begin
        resp_word = '0;
        resp_word[`FRAME_MSB] = err_q;
        resp_word[`FRAME_MSB-1 -: `FAULT_W] = chip_fault_field;
        resp_word[`FRAME_MSB-1-`FAULT_W -: `ADDR_W] = echo_q;
        resp_word[`MOSI_DATA_HI:`MOSI_DATA_LO] = reg_rdata;
        resp_word[`CRC_HI:`CRC_LO] = frame_crc(resp_word);
    end

    // engine: shift on sclk edges, judge at close, apply via fifo
    always_comb
    begin
        st_d     = st_q;
        rx_d     = rx_q;
        tx_d     = tx_q;
        obuf_d   = obuf_q;
        nrise_d  = nrise_q;
        nfall_d  = nfall_q;
        fc_exp_d = fc_exp_q;
        err_d    = err_q;
        sdo_d    = sdo_q;
        oe_d     = oe_q;
        echo_d   = echo_q;
        tm_d     = tm_q;
        unique case (st_q)
            ST_IDLE:
            begin
                oe_d = 1'b0;
                if (cs_fall)
                begin
                    // previous answer starts out now, msb first
                    tx_d    = obuf_q;
                    sdo_d   = obuf_q[`FRAME_MSB];
                    oe_d    = 1'b1;
                    nrise_d = `CNT_ZERO;
                    nfall_d = `CNT_ZERO;
                    st_d    = ST_FRAME;
                end
            end
            ST_FRAME:
            begin
                if (sck_fall)
                begin
                    rx_d    = {rx_q[`FRAME_MSB-1:0], sdi_sync_q[1]};
                    nfall_d = nfall_q + `CNT_ONE;
                end
                if (sck_rise)
                begin
                    // first rise only counts; the msb stays on sdo until the second rise
                    if (nrise_q != `CNT_ZERO)
                    begin
                        tx_d  = {tx_q[`FRAME_MSB-1:0], 1'b0};
                        sdo_d = tx_q[`FRAME_MSB-1];
                    end
                    nrise_d = nrise_q + `CNT_ONE;
                end
                if (cs_rise)
                begin
                    oe_d = 1'b0;
                    st_d = ST_CHECK;
                end
            end
            ST_CHECK:
            begin
                if (!frame_ok)
                begin
                    err_d = 1'b1;
                    st_d  = ST_APPLY;
                end
                else if (fifo_in_ready)
                begin
                    // toggle bit expected to alternate from one accepted frame to the next
                    err_d    = 1'b0;
                    fc_exp_d = ~fc_exp_q;
                    tm_d     = rx_q[`MOSI_TM];
                    st_d     = ST_APPLY;
                end
            end
            ST_APPLY:
            begin
                // wait until the command has reached the register side
                if (!cmd_valid && !reg_wr_q)
                begin
                    obuf_d = resp_word;
                    st_d   = ST_IDLE;
                end
            end
            default:
                st_d = ST_IDLE;
        endcase
        if (cmd_pop)
            echo_d = cmd_word[`CMD_W-2 -: `ADDR_W];
    end

    // obuf resets to a zero answer that still carries a valid crc
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st_q     <= ST_IDLE;
            rx_q     <= '0;
            tx_q     <= '0;
            obuf_q   <= `RESP_RST;
            nrise_q  <= `CNT_ZERO;
            nfall_q  <= `CNT_ZERO;
            fc_exp_q <= 1'b0;
            err_q    <= 1'b0;
            sdo_q    <= 1'b0;
            oe_q     <= 1'b0;
            echo_q   <= '0;
            tm_q     <= 1'b0;
        end
        else if (clk_en)
        begin
            st_q     <= st_d;
            rx_q     <= rx_d;
            tx_q     <= tx_d;
            obuf_q   <= obuf_d;
            nrise_q  <= nrise_d;
            nfall_q  <= nfall_d;
            fc_exp_q <= fc_exp_d;
            err_q    <= err_d;
            sdo_q    <= sdo_d;
            oe_q     <= oe_d;
            echo_q   <= echo_d;
            tm_q     <= tm_d;
        end
    end

    // sdo only ever carries the shift register, never sdi
    assign sdo_o  = sdo_q;
    assign sdo_oe = oe_q;
    assign frame_err_q      = err_q;
    assign test_mode_flag_q = tm_q;

    // push only good frames, so bad ones never reach registers
    cmd_fifo #(
        .WIDTH (`CMD_W),
        .DEPTH (`FIFO_DEPTH),
        .AW    (`FIFO_AW)
    ) u_cmd_fifo (
        .ref_clk   (ref_clk),
        .rstn      (rstn),
        .clk_en    (clk_en),
        .in_valid  ((st_q == ST_CHECK) && frame_ok),
        .in_ready  (fifo_in_ready),
        .in_data   (cmd_in),
        .out_valid (cmd_valid),
        .out_ready (cmd_pop),
        .out_data  (cmd_word)
    );

    // register strobe: write pulse for writes, address for both
    logic                reg_wr_d;
    logic [`ADDR_W-1:0]  reg_addr_d;
    logic [`DATA_W-1:0]  reg_wdata_d;

    assign cmd_pop = cmd_valid & ~reg_wr_q;

    always_comb
    begin
        reg_wr_d    = 1'b0;
        reg_addr_d  = reg_addr_q;
        reg_wdata_d = reg_wdata_q;
        if (cmd_pop)
        begin
            reg_wr_d    = cmd_word[`CMD_W-1];
            reg_addr_d  = cmd_word[`CMD_W-2 -: `ADDR_W];
            reg_wdata_d = cmd_word[`DATA_W-1:0];
        end
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            reg_wr_q    <= 1'b0;
            reg_addr_q  <= '0;
            reg_wdata_q <= '0;
        end
        else if (clk_en)
        begin
            reg_wr_q    <= reg_wr_d;
            reg_addr_q  <= reg_addr_d;
            reg_wdata_q <= reg_wdata_d;
        end
    end
endmodule

// file: spi_master_model.sv
// spi master model driving frames into the port
`timescale 1ns/1ns
module spi_master_model
(
    output logic      chip_select_n,
    output logic      sclk,
    output logic      sdi,
    input  wire logic sdo_line
);
    localparam int HALF = 80;
    // idle: deselected, clock parked low between frames
    initial
    begin
        chip_select_n = 1'b1;
        sclk          = 1'b0;
        sdi           = 1'b0;
    end
    // n pulses; shift on rise, capture on fall, msb first
    task automatic xfer(input logic [31:0] tx, input int n,
                        output logic [31:0] rx);
        rx = 32'h0000_0000;
        #3;
        chip_select_n = 1'b0;
        #200;
        for (int i = 0; i < n; i++)
        begin
            sclk = 1'b1;
            sdi  = tx[31 - (i % 32)];
            #HALF;
            sclk = 1'b0;
            if (i < 32)
                rx = {rx[30:0], sdo_line};
            #HALF;
        end
        #100;
        chip_select_n = 1'b1;
        sdi = ~sdi; // released line must not keep its last level
        #700;
    endtask
    // clock and data noise while deselected
    task automatic noise();
        repeat (6)
        begin
            #7 sclk = ~sclk;
            sdi = ~sdi;
        end
    endtask
endmodule

// file: spi_slave_frame_port_props.sv
// concurrent checks on the spi frame port pins
`timescale 1ns/1ns
module spi_slave_frame_port_props
(
    input wire logic        ref_clk,
    input wire logic        rstn,
    input wire logic        clk_en,
    input wire logic        chip_select_n,
    input wire logic        sclk,
    input wire logic        sdi,
    input wire logic        sdo_o,
    input wire logic        sdo_oe,
    input wire logic [1:0]  chip_fault_field,
    input wire logic        reg_wr_q,
    input wire logic [7:0]  reg_addr_q,
    input wire logic [15:0] reg_wdata_q,
    input wire logic [15:0] reg_rdata,
    input wire logic        frame_err_q,
    input wire logic        test_mode_flag_q
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    // output released once deselect has settled through the sync
    sdo_release_a: assert property (chip_select_n [*8] |-> !sdo_oe)
        else $error("sdo driven while deselected");
    oe_start_a: assert property ($fell(chip_select_n) |-> ##[2:8] (sdo_oe || chip_select_n))
        else $error("sdo not enabled after select");
    oe_frame_a: assert property ($rose(sdo_oe) |-> !chip_select_n)
        else $error("sdo enabled outside a frame");
    wr_strobe_a: assert property (reg_wr_q |=> !reg_wr_q)
        else $error("write strobe longer than one cycle");
    wr_at_end_a: assert property (reg_wr_q |-> chip_select_n && $past(chip_select_n, 2))
        else $error("write strobe before frame end");
    err_at_end_a: assert property ($changed(frame_err_q) |-> chip_select_n)
        else $error("error flag moved inside a frame");
    hold_in_frame_a: assert property (!chip_select_n && !$past(chip_select_n) |-> $stable({reg_addr_q, reg_wdata_q, frame_err_q}))
        else $error("command outputs moved inside a frame");
    wr_clear_err_a: assert property (reg_wr_q |-> ##[0:6] !frame_err_q)
        else $error("valid write left error flag set");
    cover property ($rose(reg_wr_q));
    cover property ($rose(frame_err_q));
    cover property ($rose(sdo_oe));
endmodule
bind spi_slave_frame_port spi_slave_frame_port_props chk
(
    .ref_clk, .rstn, .clk_en, .chip_select_n, .sclk, .sdi, .sdo_o,
    .sdo_oe, .chip_fault_field, .reg_wr_q, .reg_addr_q, .reg_wdata_q,
    .reg_rdata, .frame_err_q, .test_mode_flag_q
);

// file: spi_slave_frame_port_tb.sv
// self-checking bench for the spi frame port
`timescale 1ns/1ns
`define CHK(nm, ex, gt) \
    begin \
        samples_checked++; \
        if ((ex) !== (gt)) \
        begin \
            n_fail++; \
            $display("ERROR %s exp %h got %h", nm, ex, gt); \
        end \
    end
module spi_slave_frame_port_tb;
    typedef struct packed {
        logic        rw;
        logic [7:0]  a;
        logic [15:0] d;
        logic [1:0]  f;
    } row_t;
    int          n_fail          = 0;
    int          samples_checked = 0;
    logic        ref_clk, rstn, clk_en, chip_select_n, sclk, sdi;
    logic        sdo_o, sdo_oe, reg_wr_q, frame_err_q, test_mode_flag_q;
    logic [1:0]  chip_fault_field;
    logic [7:0]  reg_addr_q, last;
    logic [15:0] reg_wdata_q, reg_rdata;
    logic [15:0] regs [256];
    logic [15:0] shadow [256];
    logic [31:0] rx, exp_rsp;
    logic        tog;
    wire         sdo_line;
    row_t rows [7] = '{'{1'b1, 8'hc7, 16'habcd, 2'h1},
        '{1'b0, 8'hc7, 16'h0000, 2'h2}, '{1'b1, 8'h00, 16'hffff, 2'h3},
        '{1'b1, 8'hff, 16'h0001, 2'h0}, '{1'b0, 8'h4a, 16'h0000, 2'h1},
        '{1'b0, 8'hff, 16'h0000, 2'h2}, '{1'b0, 8'hff, 16'h0000, 2'h0}};

    spi_slave_frame_port dut (.ref_clk, .rstn, .clk_en, .chip_select_n,
        .sclk, .sdi, .sdo_o, .sdo_oe, .chip_fault_field, .reg_wr_q,
        .reg_addr_q, .reg_wdata_q, .reg_rdata, .frame_err_q,
        .test_mode_flag_q);
    spi_master_model m (.chip_select_n, .sclk, .sdi, .sdo_line);

    // pin level: nobody drives it while the port is released
    assign sdo_line  = sdo_oe ? sdo_o : 1'bz;
    // register file on the far side of the command path
    assign reg_rdata = regs[reg_addr_q];
    always @(posedge ref_clk)
        if (reg_wr_q)
            regs[reg_addr_q] <= reg_wdata_q;

    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // crc over bits 31..5, toggle bit left out
    function automatic logic [4:0] crc5(input logic [31:0] w);
        logic [4:0] c;
        c = 5'h1f;
        for (int i = 31; i >= 5; i--)
            if (i != 21)
                c = {c[3:0], 1'b0} ^ ((c[4] ^ w[i]) ? 5'h05 : 5'h00);
        return c;
    endfunction

    // one frame; bad[4:0] spoils crc, bad[5] spoils the toggle bit
    task automatic run(input row_t r, input int n, input logic [5:0] bad);
        logic [31:0] w;
        logic        ok;
        logic [31:0] want;
        @(posedge ref_clk);
        chip_fault_field <= r.f;
        w = {r.rw, r.a, 1'b0, tog ^ bad[5], r.d, 5'h00};
        w[4:0] = crc5(w) ^ bad[4:0];
        m.xfer(w, n, rx);
        // a short frame only brings out the first n bits of the answer
        want = (n < 32) ? exp_rsp >> (32 - n) : exp_rsp;
        `CHK("miso", want, rx)
        `CHK("sdo_oe", 1'b0, sdo_oe)
        ok = (n == 32) && (bad == 6'h00);
        if (ok)
        begin
            if (r.rw)
                shadow[r.a] = r.d;
            tog  = ~tog;
            last = r.a;
        end
        `CHK("reg", shadow[r.a], regs[r.a])
        `CHK("err", !ok, frame_err_q)
        `CHK("addr", last, reg_addr_q)
        `CHK("tm", 1'b0, test_mode_flag_q)
        exp_rsp = {!ok, r.f, last, shadow[last], 5'h00};
        exp_rsp[4:0] = crc5(exp_rsp);
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // hang guard, well past the expected run length
    initial
    begin
        #300000;
        n_fail++;
        give_verdict();
    end

    initial
    begin
        rstn = 1'b0;
        clk_en = 1'b1;
        chip_fault_field = 2'h0;
        tog = 1'b0;
        last = 8'h00;
        for (int i = 0; i < 256; i++)
        begin
            regs[i]   = {i[7:0], ~i[7:0]};
            shadow[i] = {i[7:0], ~i[7:0]};
        end
        exp_rsp = {27'h0, crc5(32'h0)};
        // reference frames: the bench crc must match known words
        `CHK("crc_ref_w", 5'h18, crc5(32'he395_79b8))
        `CHK("crc_ref_fc", 5'h11, crc5(32'h2520_0011))
        repeat (5) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge ref_clk);
        foreach (rows[i])
            run(rows[i], 32, 6'h00);
        // corrupted frames must not reach the register file
        run('{1'b1, 8'h10, 16'h5a5a, 2'h1}, 32, 6'h01);
        run('{1'b1, 8'h10, 16'h5a5a, 2'h1}, 31, 6'h00);
        run('{1'b1, 8'h10, 16'h5a5a, 2'h1}, 33, 6'h00);
        run('{1'b1, 8'h10, 16'h5a5a, 2'h1}, 32, 6'h20);
        m.noise();
        run(rows[1], 32, 6'h00);
        // second reset mid-run: zero answer again, toggle restarts
        @(posedge ref_clk);
        rstn <= 1'b0;
        repeat (5) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge ref_clk);
        `CHK("rst_addr", 8'h00, reg_addr_q)
        tog = 1'b0;
        last = 8'h00;
        exp_rsp = {27'h0, crc5(32'h0)};
        run(rows[2], 32, 6'h00);
        run(rows[4], 32, 6'h00);
        give_verdict();
    end
endmodule
